// *** design/sek_eeprom.sv ***
// Serial EEPROM device logic: three-wire front end, write engine, array
`timescale 1ns/1ps
`default_nettype none
`include "sek_regs.svh"

module sek_eeprom #(
  parameter int unsigned WRITE_CYCLES = `SEK_WRITE_CYCLES,
  parameter int unsigned BUF_DEPTH = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Three-wire serial link
  input wire logic chip_select,
  input wire logic serial_shift_clock,
  input wire logic serial_data_in,
  output logic serial_data_out,
  output logic serial_data_out_oe,
  // Organisation strap
  input wire logic word_width_select,
  input wire logic word_width_driven,
  // Status
  output logic program_enabled,
  output logic write_busy
);

  localparam int unsigned PW = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
  localparam int unsigned TW = $clog2(WRITE_CYCLES + 1);

  // ---------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------
  sek_pkg::sek_state_t st_r;
  logic shclk_q_r;
  logic [4:0] cnt_r;
  logic [1:0] op_r;
  logic [6:0] addr_r;
  logic [15:0] sh_r;
  logic [15:0] rd_sh_r;
  logic pe_r;
  logic stat_r;
  logic dout_r;
  logic oe_r;
  logic push_r;
  sek_pkg::sek_wreq_t req_r;
  sek_pkg::sek_wreq_t buf_r [BUF_DEPTH];
  logic [PW-1:0] wp_r;
  logic [PW-1:0] rp_r;
  logic [PW:0] fill_r;
  logic eng_busy_r;
  logic [TW-1:0] tmr_r;
  sek_pkg::sek_wreq_t cur_r;
  logic busy_out_r;
  logic [7:0] mem [`SEK_ARRAY_BYTES];

  // ---------------------------------------------------------------------
  // Decoding
  // ---------------------------------------------------------------------
  // Floating strap means x16, as the internal pull-up would give
  wire x16 = ~word_width_driven | word_width_select;
  wire shclk_rise = serial_shift_clock & ~shclk_q_r;
  wire bit_in = chip_select & shclk_rise;
  wire [4:0] abits = x16 ? `SEK_ABITS_X16 : `SEK_ABITS_X8;
  wire [4:0] dbits = x16 ? `SEK_DBITS_X16 : `SEK_DBITS_X8;
  wire [6:0] full_addr = {addr_r[5:0], serial_data_in};
  // Extended sub-command sits in the two leading address bits
  wire [1:0] ext = x16 ? full_addr[5:4] : full_addr[6:5];
  wire [15:0] full_data = {sh_r[14:0], serial_data_in};
  wire addr_last = (cnt_r == abits - 5'h01);
  wire data_last = (cnt_r == dbits - 5'h01);
  wire [6:0] lo_idx = {full_addr[5:0], 1'b0};
  wire [6:0] hi_idx = {full_addr[5:0], 1'b1};
  // x8 data is left-aligned so both widths shift out from bit 15
  wire [15:0] rd_word = x16 ? {mem[hi_idx], mem[lo_idx]}
                            : {mem[full_addr], 8'h00};
  wire buf_full = (fill_r == (PW+1)'(BUF_DEPTH));
  wire buf_empty = (fill_r == '0);
  wire push_ok = push_r & ~buf_full;
  wire pop = ~eng_busy_r & ~buf_empty;
  wire eng_done = eng_busy_r & (tmr_r == '0);
  // Device is ready only when nothing is running or queued
  wire ready = ~eng_busy_r & buf_empty & ~push_r;

  // Programming request gate: dropped while program enable is clear
  function automatic logic prog_ok(input logic pe);
    return pe;
  endfunction

  // ---------------------------------------------------------------------
  // Serial front end
  // ---------------------------------------------------------------------
  // Shift clock is sampled on clk; its rising edge steps the sequence
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      shclk_q_r <= 1'b0;
    end else begin
      shclk_q_r <= serial_shift_clock;
    end
  end

  // Instruction sequencer, restarted whenever chip select is low
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= sek_pkg::SEK_ST_IDLE;
      cnt_r <= 5'h00;
      op_r <= 2'h0;
      addr_r <= 7'h00;
      sh_r <= 16'h0000;
      rd_sh_r <= 16'h0000;
      pe_r <= 1'b0;
      push_r <= 1'b0;
      req_r <= '0;
    end else begin
      push_r <= push_r & buf_full;
      if (!chip_select) begin
        st_r <= sek_pkg::SEK_ST_IDLE;
      end else if (shclk_rise) begin
        cnt_r <= cnt_r + 5'h01;
        case (st_r)
          sek_pkg::SEK_ST_IDLE: begin
            cnt_r <= 5'h00;
            if (serial_data_in) begin
              st_r <= sek_pkg::SEK_ST_OPC;
            end
          end
          sek_pkg::SEK_ST_OPC: begin
            op_r <= {op_r[0], serial_data_in};
            if (cnt_r == 5'h01) begin
              st_r <= sek_pkg::SEK_ST_ADDR;
              cnt_r <= 5'h00;
            end
          end
          sek_pkg::SEK_ST_ADDR: begin
            addr_r <= full_addr;
            if (addr_last) begin
              cnt_r <= 5'h00;
              st_r <= sek_pkg::SEK_ST_DONE;
              req_r <= '{sek_pkg::SEK_ER_WORD, x16, full_addr, 16'h0000};
              case (op_r)
                `SEK_OP_READ: begin
                  rd_sh_r <= rd_word;
                  st_r <= sek_pkg::SEK_ST_READ;
                end
                `SEK_OP_WRITE: st_r <= sek_pkg::SEK_ST_DATA;
                `SEK_OP_ERASE: push_r <= prog_ok(pe_r);
                default: begin
                  case (ext)
                    `SEK_EXT_PROG_EN: pe_r <= 1'b1;
                    `SEK_EXT_PROG_DIS: pe_r <= 1'b0;
                    `SEK_EXT_ERASE_ALL: begin
                      req_r.kind <= sek_pkg::SEK_ER_ALL;
                      push_r <= prog_ok(pe_r);
                    end
                    default: st_r <= sek_pkg::SEK_ST_DATA;
                  endcase
                end
              endcase
            end
          end
          sek_pkg::SEK_ST_DATA: begin
            sh_r <= full_data;
            if (data_last) begin
              st_r <= sek_pkg::SEK_ST_DONE;
              req_r.data <= full_data;
              req_r.kind <= (op_r == `SEK_OP_WRITE) ? sek_pkg::SEK_WR_WORD
                                                    : sek_pkg::SEK_WR_ALL;
              push_r <= prog_ok(pe_r);
            end
          end
          sek_pkg::SEK_ST_READ: begin
            rd_sh_r <= {rd_sh_r[14:0], 1'b0};
            if (data_last) begin
              st_r <= sek_pkg::SEK_ST_DONE;
            end
          end
          sek_pkg::SEK_ST_DONE: st_r <= sek_pkg::SEK_ST_DONE;
          default: st_r <= sek_pkg::SEK_ST_IDLE;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------------
  // Serial output and ready/busy status
  // ---------------------------------------------------------------------
  // Status is armed by a write start and dropped by the next start bit
  wire start_bit = bit_in & serial_data_in & (st_r == sek_pkg::SEK_ST_IDLE);
  wire rd_first = bit_in & (st_r == sek_pkg::SEK_ST_ADDR) & addr_last &
                  (op_r == `SEK_OP_READ);
  wire rd_shift = bit_in & (st_r == sek_pkg::SEK_ST_READ);
  wire rd_drive = (st_r == sek_pkg::SEK_ST_READ) |
                  ((st_r == sek_pkg::SEK_ST_DONE) & (op_r == `SEK_OP_READ));
  wire stat_show = chip_select & stat_r & (st_r == sek_pkg::SEK_ST_IDLE);
  // Read bits change only on a rising edge; status follows the engine
  wire dout_nxt = rd_first ? 1'b0 :
                  rd_shift ? rd_sh_r[15] :
                  rd_drive ? dout_r :
                  ready;
  wire oe_nxt = chip_select & ~start_bit &
                (rd_drive | stat_show | rd_first | rd_shift);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stat_r <= 1'b0;
      dout_r <= 1'b0;
      oe_r <= 1'b0;
      busy_out_r <= 1'b0;
    end else begin
      stat_r <= push_ok | (stat_r & ~start_bit);
      dout_r <= dout_nxt;
      oe_r <= oe_nxt;
      busy_out_r <= ~ready;
    end
  end

  // ---------------------------------------------------------------------
  // Request buffer between front end and write engine
  // ---------------------------------------------------------------------
  // A full buffer holds the pending request rather than losing it
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wp_r <= '0;
      rp_r <= '0;
      fill_r <= '0;
    end else begin
      if (push_ok) begin
        wp_r <= (wp_r == PW'(BUF_DEPTH - 1)) ? '0 : wp_r + PW'(1);
      end
      if (pop) begin
        rp_r <= (rp_r == PW'(BUF_DEPTH - 1)) ? '0 : rp_r + PW'(1);
      end
      fill_r <= fill_r + {{PW{1'b0}}, push_ok} - {{PW{1'b0}}, pop};
    end
  end

  always_ff @(posedge clk) begin
    if (push_ok) begin
      buf_r[wp_r] <= req_r;
    end
  end

  // ---------------------------------------------------------------------
  // Self-timed write engine
  // ---------------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      eng_busy_r <= 1'b0;
      tmr_r <= '0;
      cur_r <= '0;
    end else if (pop) begin
      eng_busy_r <= 1'b1;
      tmr_r <= TW'(WRITE_CYCLES - 1);
      cur_r <= buf_r[rp_r];
    end else if (eng_done) begin
      eng_busy_r <= 1'b0;
    end else if (eng_busy_r) begin
      tmr_r <= tmr_r - TW'(1);
    end
  end

  // Array update at the end of the cycle; writes overwrite directly
  generate
    for (genvar i = 0; i < `SEK_ARRAY_BYTES; i++) begin : g_byte
      wire hit = cur_r.x16 ? (cur_r.addr[5:0] == 6'(i >> 1))
                           : (cur_r.addr == 7'(i));
      wire all = cur_r.kind[1];
      wire [7:0] wval = (cur_r.x16 && (i % 2 == 1)) ? cur_r.data[15:8]
                                                     : cur_r.data[7:0];
      wire [7:0] val = cur_r.kind[0] ? `SEK_ERASED_BYTE : wval;
      always_ff @(posedge clk) begin
        if (eng_done && (all || hit)) begin
          mem[i] <= val;
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------
  assign serial_data_out = dout_r;
  assign serial_data_out_oe = oe_r;
  assign program_enabled = pe_r;
  assign write_busy = busy_out_r;

endmodule
`default_nettype wire

// *** design/sek_regs.svh ***
// Constants of the serial EEPROM access block: opcodes, sizes and timing
`ifndef SEK_REGS_SVH
`define SEK_REGS_SVH

// ---------------------------------------------------------------------
// Timing
// ---------------------------------------------------------------------
`define SEK_CLK_PERIOD_NS 25
`define SEK_WRITE_TIME_NS 5000000
// Longest time, so rounded down to whole clock cycles
`define SEK_WRITE_CYCLES (`SEK_WRITE_TIME_NS / `SEK_CLK_PERIOD_NS)

// ---------------------------------------------------------------------
// Array and opcodes
// ---------------------------------------------------------------------
`define SEK_ARRAY_BYTES 128
`define SEK_ERASED_BYTE 8'hFF
`define SEK_OP_READ 2'h2
`define SEK_OP_WRITE 2'h1
`define SEK_OP_ERASE 2'h3
`define SEK_OP_EXT 2'h0
`define SEK_EXT_PROG_EN 2'h3
`define SEK_EXT_ERASE_ALL 2'h2
`define SEK_EXT_WRITE_ALL 2'h1
`define SEK_EXT_PROG_DIS 2'h0
`define SEK_ABITS_X16 5'h06
`define SEK_ABITS_X8 5'h07
`define SEK_DBITS_X16 5'h10
`define SEK_DBITS_X8 5'h08

`endif

// *** design/sek_pkg.sv ***
// Types shared by the serial EEPROM access block
package sek_pkg;

  // Kind of self-timed programming operation
  typedef enum logic [1:0] {
    SEK_WR_WORD = 2'h0,
    SEK_ER_WORD = 2'h1,
    SEK_WR_ALL  = 2'h2,
    SEK_ER_ALL  = 2'h3
  } sek_wkind_t;

  // Serial front-end states, Gray coded along the usual path
  typedef enum logic [2:0] {
    SEK_ST_IDLE = 3'h0,
    SEK_ST_OPC  = 3'h1,
    SEK_ST_ADDR = 3'h3,
    SEK_ST_DATA = 3'h2,
    SEK_ST_READ = 3'h7,
    SEK_ST_DONE = 3'h6
  } sek_state_t;

  // One programming request as it travels through the buffer
  typedef struct packed {
    sek_wkind_t kind;
    logic x16;
    logic [6:0] addr;
    logic [15:0] data;
  } sek_wreq_t;

endpackage

// *** testbench/sek_eeprom_monitor.sv ***
// Pin-level checks for the serial EEPROM device
`timescale 1ns/1ps
`default_nettype none
module sek_eeprom_monitor #(
  parameter int unsigned WRITE_CYCLES = 20
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Serial link
  input wire logic chip_select,
  input wire logic serial_shift_clock,
  input wire logic serial_data_in,
  input wire logic serial_data_out,
  input wire logic serial_data_out_oe,
  // Strap and status
  input wire logic word_width_select,
  input wire logic word_width_driven,
  input wire logic program_enabled,
  input wire logic write_busy
);
  // Room for two queued words behind the running one
  localparam int WMAX = 3 * WRITE_CYCLES + 16;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  // ------------------------------------------------------------------
  // Output enable and status
  // ------------------------------------------------------------------
  AST_OE_DROP: assert property (
    !chip_select |=> !serial_data_out_oe)
    else $error("output still enabled after chip select low");
  AST_OE_CS: assert property (
    serial_data_out_oe |-> $past(chip_select))
    else $error("output enabled without chip select");
  AST_PE_CS: assert property (
    $changed(program_enabled) |-> $past(chip_select))
    else $error("program enable changed without chip select");
  AST_STAT_BUSY: assert property (
    $rose(serial_data_out_oe) && write_busy |-> !serial_data_out)
    else $error("status not low while busy");
  AST_STAT_READY: assert property (
    $fell(write_busy) && chip_select && serial_data_out_oe |->
    ##[0:2] serial_data_out)
    else $error("status not high after write end");
  // Status changes are not tied to the shift clock, so skip them
  AST_READ_EDGE: assert property (
    serial_data_out_oe && $past(serial_data_out_oe) &&
    $changed(serial_data_out) && !write_busy && !$past(write_busy) &&
    !$past(write_busy, 2) |->
    $past(serial_shift_clock) && !$past(serial_shift_clock, 2))
    else $error("read bit changed off a shift clock rise");
  // ------------------------------------------------------------------
  // Write engine
  // ------------------------------------------------------------------
  AST_PROG_GATE: assert property (
    !program_enabled && !write_busy |=> !write_busy)
    else $error("write started while programming disabled");
  AST_BUSY_MIN: assert property (
    $rose(write_busy) |-> write_busy [*8])
    else $error("write cycle ended too early");
  AST_BUSY_MAX: assert property (
    $rose(write_busy) |-> ##[1:WMAX] !write_busy)
    else $error("write cycle did not end in time");
  COV_READ: cover property ($rose(serial_data_out_oe) && !write_busy);
  COV_WRITE: cover property ($rose(write_busy));
  COV_READY: cover property ($fell(write_busy) && serial_data_out_oe);
endmodule
`default_nettype wire

// *** testbench/sek_host_model.sv ***
// Host side of the three-wire link: frames and status polling
`timescale 1ns/1ps
`default_nettype none
module sek_host_model (
  // Clock
  input wire logic clk,
  // Three-wire link, host side
  output logic chip_select,
  output logic serial_shift_clock,
  output logic serial_data_in,
  input wire logic serial_data_out,
  input wire logic serial_data_out_oe
);
  // Released output reads as the inverse, so a sample taken while the
  // device is not driving shows up as a wrong bit
  wire logic data_line = serial_data_out_oe ? serial_data_out
                                            : ~serial_data_out;
  // Link idle with the shift clock standing low
  initial begin
    chip_select = 1'b0;
    serial_shift_clock = 1'b0;
    serial_data_in = 1'b0;
  end
  // Sends n bits MSB first; each level held for several clocks
  task automatic frame(input logic [31:0] bits, input int n,
                       output logic [31:0] got);
    got = '0;
    @(posedge clk) chip_select <= 1'b1;
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge clk) serial_shift_clock <= 1'b0;
      serial_data_in <= bits[i];
      @(posedge clk);
      @(posedge clk) serial_shift_clock <= 1'b1;
      repeat (3) @(posedge clk);
      got = {got[30:0], data_line};
    end
    @(posedge clk) chip_select <= 1'b0;
    serial_shift_clock <= 1'b0;
    serial_data_in <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  // Raises chip select alone and polls ready/busy, bounded
  task automatic status(output logic oe, output logic first,
                        output logic last);
    @(posedge clk) chip_select <= 1'b1;
    repeat (3) @(posedge clk);
    oe = serial_data_out_oe;
    first = data_line;
    last = first;
    for (int i = 0; i < 200 && last !== 1'b1; i++) begin
      @(posedge clk);
      last = data_line;
    end
    @(posedge clk) chip_select <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// *** testbench/sek_eeprom_tb_top.sv ***
// Self-checking bench for the serial EEPROM device
`timescale 1ns/1ps
`default_nettype none
`include "sek_regs.svh"
module sek_eeprom_tb_top;
  localparam int unsigned WCYC = 20;
  logic clk;
  logic nrst;
  logic word_width_select;
  logic word_width_driven;
  logic x16;
  logic oe;
  logic b0;
  logic b1;
  logic [31:0] got;
  int mismatches;
  int checks;
  wire logic chip_select;
  wire logic serial_shift_clock;
  wire logic serial_data_in;
  wire logic serial_data_out;
  wire logic serial_data_out_oe;
  wire logic program_enabled;
  wire logic write_busy;
  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  sek_eeprom #(.WRITE_CYCLES(WCYC)) i_dut (.clk(clk), .nrst(nrst),
    .chip_select(chip_select), .serial_shift_clock(serial_shift_clock),
    .serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
    .serial_data_out_oe(serial_data_out_oe),
    .word_width_select(word_width_select),
    .word_width_driven(word_width_driven),
    .program_enabled(program_enabled), .write_busy(write_busy));
  sek_host_model i_host (.clk(clk), .chip_select(chip_select),
    .serial_shift_clock(serial_shift_clock),
    .serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
    .serial_data_out_oe(serial_data_out_oe));
  // ------------------------------------------------------------------
  // Access tasks
  // ------------------------------------------------------------------
  task automatic stop_test();
    if (mismatches == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] seen,
                     input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Start bit, opcode, address for the current width, nd data bits
  task automatic op(input logic [1:0] opc, input logic [6:0] a,
                    input logic [15:0] d, input int nd);
    int ab;
    ab = x16 ? 6 : 7;
    i_host.frame(({29'h0, 1'b1, opc} << (ab + nd)) | ({25'h0, a} << nd)
      | {16'h0, d}, 3 + ab + nd, got);
  endtask
  task automatic ext(input logic [1:0] code, input logic [15:0] d,
                     input int nd);
    op(`SEK_OP_EXT, x16 ? {1'b0, code, 4'h0} : {code, 5'h0}, d, nd);
  endtask
  // Bounded wait for the write engine to go idle
  task automatic wdone();
    int i;
    for (i = 0; i < 200 && write_busy !== 1'b0; i++) @(posedge clk);
    if (i == 200) begin
      mismatches++;
      stop_test();
    end
  endtask
  task automatic rd(input logic [6:0] a, input logic [15:0] exp);
    op(`SEK_OP_READ, a, 16'h0000, x16 ? 16 : 8);
    chk("read data", x16 ? got[15:0] : {8'h00, got[7:0]}, exp);
    chk("dummy bit", {15'h0000, got[x16 ? 16 : 8]}, 16'h0000);
  endtask
  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    nrst = 1'b0;
    word_width_select = 1'b1;
    word_width_driven = 1'b1;
    x16 = 1'b1;
    mismatches = 0;
    checks = 0;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    chk("enable at reset", {15'h0, program_enabled}, 16'h0000);
    op(`SEK_OP_WRITE, 7'h05, 16'h1234, 16);
    repeat (4) @(posedge clk);
    chk("busy when disabled", {15'h0, write_busy}, 16'h0000);
    ext(`SEK_EXT_PROG_EN, 16'h0000, 0);
    chk("enable set", {15'h0, program_enabled}, 16'h0001);
    op(`SEK_OP_WRITE, 7'h05, 16'hA55A, 16);
    i_host.status(oe, b0, b1);
    chk("status enable", {15'h0, oe}, 16'h0001);
    chk("status busy", {15'h0, b0}, 16'h0000);
    chk("status ready", {15'h0, b1}, 16'h0001);
    wdone();
    rd(7'h05, 16'hA55A);
    op(`SEK_OP_WRITE, 7'h05, 16'h3C0F, 16);
    wdone();
    rd(7'h05, 16'h3C0F);
    word_width_select <= 1'b0;
    x16 = 1'b0;
    rd(7'h0A, 16'h000F);
    rd(7'h0B, 16'h003C);
    word_width_driven <= 1'b0;
    x16 = 1'b1;
    rd(7'h05, 16'h3C0F);
    word_width_driven <= 1'b1;
    word_width_select <= 1'b1;
    op(`SEK_OP_ERASE, 7'h05, 16'h0000, 0);
    wdone();
    rd(7'h05, {2{`SEK_ERASED_BYTE}});
    word_width_select <= 1'b0;
    x16 = 1'b0;
    ext(`SEK_EXT_WRITE_ALL, 16'h005A, 8);
    wdone();
    rd(7'h7F, 16'h005A);
    ext(`SEK_EXT_ERASE_ALL, 16'h0000, 0);
    wdone();
    rd(7'h00, {8'h00, `SEK_ERASED_BYTE});
    ext(`SEK_EXT_PROG_DIS, 16'h0000, 0);
    chk("enable cleared", {15'h0, program_enabled}, 16'h0000);
    op(`SEK_OP_WRITE, 7'h7F, 16'h0012, 8);
    wdone();
    rd(7'h7F, {8'h00, `SEK_ERASED_BYTE});
    stop_test();
  end
endmodule
bind sek_eeprom sek_eeprom_monitor #(.WRITE_CYCLES(WRITE_CYCLES)) i_mon (
  .clk(clk), .nrst(nrst), .chip_select(chip_select),
  .serial_shift_clock(serial_shift_clock), .serial_data_in(serial_data_in),
  .serial_data_out(serial_data_out),
  .serial_data_out_oe(serial_data_out_oe),
  .word_width_select(word_width_select),
  .word_width_driven(word_width_driven),
  .program_enabled(program_enabled), .write_busy(write_busy));
`default_nettype wire
